// ==== include/sait_pkg.sv ====
// Purpose: Constants for the serial audio input and transport block
// Assumes: 50 MHz system clock, bit clock sampled as an ordinary input
// Notes:   Bit clock period limits derive from the frequencies below

package sait_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned BCLK_MIN_HZ  = 1_000_000;
  localparam int unsigned BCLK_MAX_HZ  = 13_000_000;
  // Shortest period rounds up, longest rounds down
  localparam logic [6:0]  BCLK_MIN_CYC = 7'((CLK_HZ + BCLK_MAX_HZ - 1) / BCLK_MAX_HZ);
  localparam logic [6:0]  BCLK_MAX_CYC = 7'(CLK_HZ / BCLK_MIN_HZ);
  localparam logic [6:0]  PER_SAT      = 7'h7F;

  // ==========================================================
  // Word and slot layout
  localparam int unsigned WORD_W       = 32;
  localparam int unsigned NUM_LANES    = 5;     // A..D plus auxiliary
  localparam int unsigned TDM_FRAME    = 256;
  localparam logic [6:0]  SLOT_BITS_8  = 7'(TDM_FRAME / 8);
  localparam logic [6:0]  SLOT_BITS_4  = 7'(TDM_FRAME / 4);
  localparam logic [2:0]  LANE_AUX     = 3'h4;
  localparam logic [4:0]  PEND_RST     = 5'h00;
  localparam logic [5:0]  CNT_MAX      = 6'h20;

  // ==========================================================
  // Transport mode, one-hot
  typedef enum logic [2:0] {
    SAIT_ISLAND   = 3'b001,
    SAIT_FRAME    = 3'b010,
    SAIT_SURROUND = 3'b100
  } sait_mode_t;
endpackage : sait_pkg

// ==== design/sait_audio_in.sv ====
// Purpose: Serial audio capture and link transport selection
// Assumes: Bit clock, word select and data arrive asynchronously
// Notes:   Output words are handed to the link framer one per cycle
`timescale 1ns/1ps
`default_nettype none

module sait_audio_in (
  input  wire logic        clk_in,              // 50 MHz system clock
  input  wire logic        srst_in,             // Synchronous reset, high
  input  wire logic        audio_bclk_in,       // Serial bit clock pin
  input  wire logic        audio_word_select_in,// Word select pin
  input  wire logic        audio_data_lane_a_in,// Data lane A pin
  input  wire logic        audio_data_lane_b_in,// Data lane B pin
  input  wire logic        audio_data_lane_c_in,// Data lane C pin
  input  wire logic        audio_data_lane_d_in,// Data lane D pin
  input  wire logic        aux_data_in,         // Auxiliary data (GP pin 0)
  input  wire logic        aux_en_in,           // GP pins 1:0 used for aux audio
  input  wire logic [6:0]  bclk_min_cycles_in,  // Half video clock limit, cycles
  input  wire logic        embedded_mode_in,    // 1: use video-embedded audio
  input  wire logic        emb_valid_in,        // Embedded audio word strobe
  input  wire logic [31:0] emb_word_in,         // Embedded audio word
  input  wire logic [2:0]  emb_slot_in,         // Embedded channel number
  input  wire logic        island_disable_in,   // 1: forward-frame transport
  input  wire logic        legacy_partner_in,   // Partner is legacy type
  input  wire logic        surround_en_in,      // Local surround enable
  input  wire logic        upstream_surround_in,// Surround set up the tree
  input  wire logic        tdm_mode_in,         // 1: TDM on lane A
  input  wire logic        tdm_eight_in,        // 1: 8x32, 0: 4x64 slots
  input  wire logic        video_blank_in,      // Video blanking interval
  input  wire logic        cipher_active_in,    // Content cipher running
  input  wire logic        auth_busy_in,        // Authentication in progress
  input  wire logic        link_lock_in,        // Serial link locked
  output logic             tx_valid_out,        // Word strobe to framer
  output logic [31:0]      tx_word_out,         // Left-aligned sample
  output logic [2:0]       tx_slot_out,         // Channel number
  output logic [2:0]       tx_lane_out,         // Source lane, 4 = aux
  output logic             tx_island_out,       // Word goes in packet island
  output logic             tx_encrypt_out,      // Word must be encrypted
  output logic             overrun_out,         // Word lost, one-cycle pulse
  output logic             bclk_ok_out,         // Bit clock in range
  output logic             surround_active_out, // Surround transport live
  output logic             video_24bit_out,     // 0: 18-bit video only
  output logic             ctrl_fwd_out,        // Auth on forward channel
  output logic             ctrl_back_out        // Auth on back channel
);

  // ==========================================================
  // Input synchronisers
  logic       bclk_s1_reg, bclk_s2_reg, bclk_s3_reg;
  logic       ws_s1_reg, ws_s2_reg;
  logic [4:0] dat_s1_reg, dat_s2_reg;
  logic       bclk_rise;

  // Two flops on every pin, edge history taken from the second
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bclk_s1_reg <= 1'b0;
      bclk_s2_reg <= 1'b0;
      bclk_s3_reg <= 1'b0;
      ws_s1_reg   <= 1'b0;
      ws_s2_reg   <= 1'b0;
      dat_s1_reg  <= 5'h00;
      dat_s2_reg  <= 5'h00;
    end else begin
      bclk_s1_reg <= audio_bclk_in;
      bclk_s2_reg <= bclk_s1_reg;
      bclk_s3_reg <= bclk_s2_reg;
      ws_s1_reg   <= audio_word_select_in;
      ws_s2_reg   <= ws_s1_reg;
      dat_s1_reg  <= {aux_data_in, audio_data_lane_d_in, audio_data_lane_c_in,
                      audio_data_lane_b_in, audio_data_lane_a_in};
      dat_s2_reg  <= dat_s1_reg;
    end
  end

  assign bclk_rise = bclk_s2_reg & ~bclk_s3_reg;

  // ==========================================================
  // Bit clock range monitor
  logic [6:0] per_cnt_reg;
  logic       bclk_ok_reg;
  logic [6:0] min_eff;

  // Lower bound is the stricter of 13 MHz and half the video clock
  assign min_eff = (bclk_min_cycles_in > sait_pkg::BCLK_MIN_CYC) ? bclk_min_cycles_in
                                                                  : sait_pkg::BCLK_MIN_CYC;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      per_cnt_reg <= 7'h00;
      bclk_ok_reg <= 1'b0;
    end else if (bclk_rise) begin
      per_cnt_reg <= 7'h00;
      bclk_ok_reg <= (per_cnt_reg + 7'h01 >= min_eff) && (per_cnt_reg + 7'h01 <= sait_pkg::BCLK_MAX_CYC);
    end else if (per_cnt_reg != sait_pkg::PER_SAT) begin
      per_cnt_reg <= per_cnt_reg + 7'h01;
      // A stopped clock drops out of range without waiting for an edge
      if (per_cnt_reg >= sait_pkg::BCLK_MAX_CYC) begin
        bclk_ok_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Transport mode selection
  sait_pkg::sait_mode_t mode_reg, mode_next;
  logic                 surr_req;

  assign surr_req = surround_en_in | upstream_surround_in;

  // surround needs island and newer partner
  always_comb begin
    if (island_disable_in) begin
      mode_next = sait_pkg::SAIT_FRAME;
    end else if (surr_req && !legacy_partner_in) begin
      mode_next = sait_pkg::SAIT_SURROUND;
    end else begin
      mode_next = sait_pkg::SAIT_ISLAND;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_reg <= sait_pkg::SAIT_ISLAND;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Lanes carried in each mode
  logic [4:0] lane_en;
  always_comb begin
    case (mode_reg)
      // lane A, plus B for legacy
      sait_pkg::SAIT_FRAME:    lane_en = legacy_partner_in ? 5'b00011 : 5'b00001;
      sait_pkg::SAIT_SURROUND: lane_en = 5'b01111;
      // Plain island mode: four channels on A and B
      sait_pkg::SAIT_ISLAND:   lane_en = 5'b00011;
      default:                 lane_en = 5'b00001;
    endcase
    if (tdm_mode_in) begin
      lane_en = 5'b00001;
    end
    // auxiliary lane independent of main stream
    lane_en[4] = aux_en_in;
  end

  // ==========================================================
  // Serial word capture
  logic [31:0] shift_reg [sait_pkg::NUM_LANES];
  logic [5:0]  cnt_reg   [sait_pkg::NUM_LANES];
  logic        ws_last_reg;
  logic [2:0]  tdm_slot_reg;
  logic [6:0]  tdm_bits_reg;
  logic        ws_edge, tdm_slot_end, word_end;

  // Left-align a word that took fewer than 32 bit clocks
  function automatic logic [31:0] align_word(input logic [31:0] w, input logic [5:0] n);
    logic [5:0] sh;
    sh = sait_pkg::CNT_MAX - n;
    align_word = w << sh;
  endfunction : align_word

  assign ws_edge      = ws_s2_reg != ws_last_reg;
  assign tdm_slot_end = tdm_bits_reg + 7'h01 ==
                        (tdm_eight_in ? sait_pkg::SLOT_BITS_8 : sait_pkg::SLOT_BITS_4);
  // slot end or new frame in TDM
  assign word_end = tdm_mode_in ? (tdm_slot_end || (ws_s2_reg && !ws_last_reg)) : ws_edge;

  // MSB first, word closes on the bit where select changes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int l = 0; l < sait_pkg::NUM_LANES; l++) begin
        shift_reg[l] <= 32'h0000_0000;
        cnt_reg[l]   <= 6'h00;
      end
    end else if (bclk_rise && bclk_ok_reg) begin
      for (int l = 0; l < sait_pkg::NUM_LANES; l++) begin
        if (word_end) begin
          shift_reg[l] <= 32'h0000_0000;
          cnt_reg[l]   <= 6'h00;
        end else if (cnt_reg[l] != sait_pkg::CNT_MAX) begin
          // Bits past 32 are dropped: long TDM slots keep their top half
          shift_reg[l] <= {shift_reg[l][30:0], dat_s2_reg[l]};
          cnt_reg[l]   <= cnt_reg[l] + 6'h01;
        end
      end
    end
  end

  // Word select history and TDM slot position
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ws_last_reg  <= 1'b0;
      tdm_slot_reg <= 3'h0;
      tdm_bits_reg <= 7'h00;
    end else if (bclk_rise && bclk_ok_reg) begin
      ws_last_reg <= ws_s2_reg;
      if (word_end) begin
        tdm_bits_reg <= 7'h00;
        tdm_slot_reg <= (ws_s2_reg && !ws_last_reg) ? 3'h0 : tdm_slot_reg + 3'h1;
      end else begin
        tdm_bits_reg <= tdm_bits_reg + 7'h01;
      end
    end
  end

  // ==========================================================
  // Captured words awaiting transport
  logic [31:0] word_reg [sait_pkg::NUM_LANES];
  logic [2:0]  slot_reg [sait_pkg::NUM_LANES];
  logic [4:0]  pend_reg;
  logic        cap_go, send_go;
  logic [2:0]  pick;

  assign cap_go = embedded_mode_in ? emb_valid_in : (bclk_rise && bclk_ok_reg && word_end);

  // Lowest pending lane first
  always_comb begin
    pick = 3'h0;
    for (int l = sait_pkg::NUM_LANES - 1; l >= 0; l--) begin
      if (pend_reg[l]) begin
        pick = 3'(l);
      end
    end
  end

  assign send_go = (pend_reg != sait_pkg::PEND_RST) &&
                   (mode_reg == sait_pkg::SAIT_FRAME || video_blank_in);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pend_reg    <= sait_pkg::PEND_RST;
      overrun_out <= 1'b0;
      for (int l = 0; l < sait_pkg::NUM_LANES; l++) begin
        word_reg[l] <= 32'h0000_0000;
        slot_reg[l] <= 3'h0;
      end
    end else begin
      overrun_out <= cap_go && ((pend_reg & lane_en) != sait_pkg::PEND_RST);
      for (int l = 0; l < sait_pkg::NUM_LANES; l++) begin
        // Capture wins over the send clear in the same cycle
        if (cap_go && lane_en[l] && (!embedded_mode_in || l == 0)) begin
          pend_reg[l] <= 1'b1;
          if (embedded_mode_in) begin
            word_reg[l] <= emb_word_in;
            slot_reg[l] <= emb_slot_in;
          end else begin
            // bit at the select change is the old word's LSB
            word_reg[l] <= (cnt_reg[l] == sait_pkg::CNT_MAX) ? shift_reg[l]
                         : align_word({shift_reg[l][30:0], dat_s2_reg[l]}, cnt_reg[l] + 6'h01);
            // channel from lane and select level
            slot_reg[l] <= tdm_mode_in ? tdm_slot_reg : {l[1:0], ws_last_reg};
          end
        end else if (send_go && pick == 3'(l)) begin
          pend_reg[l] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Word output to the link framer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_valid_out   <= 1'b0;
      tx_word_out    <= 32'h0000_0000;
      tx_slot_out    <= 3'h0;
      tx_lane_out    <= 3'h0;
      tx_island_out  <= 1'b0;
      tx_encrypt_out <= 1'b0;
    end else begin
      tx_valid_out  <= send_go;
      tx_word_out   <= word_reg[pick];
      tx_slot_out   <= slot_reg[pick];
      tx_lane_out   <= pick;
      tx_island_out <= mode_reg != sait_pkg::SAIT_FRAME;
      tx_encrypt_out <= cipher_active_in && (mode_reg != sait_pkg::SAIT_FRAME);
    end
  end

  // ==========================================================
  // Status and control channel
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      surround_active_out <= 1'b0;
      video_24bit_out     <= 1'b1;
      ctrl_fwd_out        <= 1'b0;
      ctrl_back_out       <= 1'b0;
    end else begin
      surround_active_out <= mode_reg == sait_pkg::SAIT_SURROUND;
      // legacy partner with surround drops to 18-bit
      video_24bit_out <= !(legacy_partner_in && surr_req);
      ctrl_fwd_out  <= auth_busy_in && link_lock_in;
      ctrl_back_out <= auth_busy_in && link_lock_in;
    end
  end

  assign bclk_ok_out = bclk_ok_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  bclk_low_bound_a: assert property (
    bclk_rise && per_cnt_reg + 7'h01 < min_eff |=> !bclk_ok_reg)
    else $error("bit clock too fast but accepted");
  bclk_stop_a: assert property (
    per_cnt_reg > sait_pkg::BCLK_MAX_CYC |-> !bclk_ok_reg)
    else $error("stopped bit clock still accepted");
  frame_mode_a: assert property (
    island_disable_in |=> mode_reg == sait_pkg::SAIT_FRAME)
    else $error("island disable ignored");
  frame_lanes_a: assert property (
    tx_valid_out && !tx_island_out && !legacy_partner_in |-> tx_lane_out == 3'h0 || tx_lane_out == 3'h4)
    else $error("frame transport sent extra lane");
  surround_gate_a: assert property (
    surround_active_out |-> $past(!island_disable_in, 2) && $past(!legacy_partner_in, 2))
    else $error("surround outside island with newer partner");
  island_blank_a: assert property (
    tx_valid_out && tx_island_out |-> $past(video_blank_in))
    else $error("island word sent outside blanking");
  encrypt_island_a: assert property (
    tx_valid_out && $past(cipher_active_in) && tx_island_out |-> tx_encrypt_out)
    else $error("island audio not encrypted");
  frame_clear_a: assert property (
    tx_valid_out && !tx_island_out |-> !tx_encrypt_out)
    else $error("frame audio encrypted");
  video_width_a: assert property (
    legacy_partner_in && surround_en_in |=> !video_24bit_out)
    else $error("24-bit video with legacy surround");
  aux_lane_a: assert property (
    !aux_en_in [*2] ##1 tx_valid_out |-> tx_lane_out != sait_pkg::LANE_AUX || $past(pend_reg[4], 1))
    else $error("aux lane sent while disabled");

endmodule : sait_audio_in

`default_nettype wire

// ==== sim/sait_audio_src.sv ====
// Purpose: Serial audio source model facing the capture block
// Assumes: Edges paced by the bench clock falling edge
// Notes:   Bit clock stands still low between frames
`timescale 1ns/1ps
`default_nettype none

module sait_audio_src (
  input  wire logic             clk_in,   // Bench clock
  input  wire logic [3:0]       half_in,  // Half bit period, cycles
  input  wire logic [4:0][31:0] left_in,  // Even channel words
  input  wire logic [4:0][31:0] right_in, // Odd channel words
  output logic                  bclk_out, // Bit clock
  output logic                  ws_out,   // Word select
  output logic [4:0]            data_out  // Lanes A..D, aux
);
  // ==========================================================
  // Idle levels
  initial begin
    bclk_out = 1'b0;
    ws_out   = 1'b0;
    data_out = 5'h0A;
  end

  // ==========================================================
  // Two lead-in bits, then one stereo frame
  task automatic play();
    // Idle long enough that the range monitor forgets the last frame
    repeat (60) @(negedge clk_in);
    for (int k = 0; k < 66; k++) begin
      @(negedge clk_in);
      bclk_out = 1'b0;
      ws_out = (k >= 33) && (k < 65);
      // MSB first, select leads each word by one bit
      for (int l = 0; l < 5; l++) begin
        data_out[l] = (k < 2) ? ~data_out[l] : (k <= 33) ? left_in[l][33-k] : right_in[l][65-k];
      end
      repeat (half_in) @(negedge clk_in);
      bclk_out = 1'b1;
      repeat (half_in - 4'h1) @(negedge clk_in);
    end
    @(negedge clk_in);
    bclk_out = 1'b0;
    data_out = ~data_out; // Inverted: no stale value
  endtask : play
endmodule : sait_audio_src
`default_nettype wire

// ==== sim/test_serializer_audio_input_transport.sv ====
// Purpose: Self-checking bench for audio capture and transport
// Assumes: 50 MHz clock, bit clock 8 cycles unless refused
// Notes:   Words compared as {lane, slot, word, island, encrypt}
`timescale 1ns/1ps
`default_nettype none

module test_serializer_audio_input_transport;
  logic clk_in, srst_in, aux_en_in, embedded_mode_in, emb_valid_in;
  logic island_disable_in, legacy_partner_in, surround_en_in, upstream_surround_in;
  logic tdm_mode_in, tdm_eight_in, video_blank_in, cipher_active_in, auth_busy_in, link_lock_in;
  logic tx_valid_out, tx_island_out, tx_encrypt_out, overrun_out, bclk_ok_out;
  logic surround_active_out, video_24bit_out, ctrl_fwd_out, ctrl_back_out, bclk, ws;
  logic [6:0]       bclk_min_cycles_in;
  logic [31:0]      emb_word_in, tx_word_out, lfsr_st, r;
  logic [2:0]       emb_slot_in, tx_slot_out, tx_lane_out;
  logic [3:0]       half;
  logic [4:0]       dat;
  logic [4:0][31:0] wl, wr;
  logic [39:0]      q[$];
  logic [39:0]      e;
  int               error_cnt, n_checks, n_ovr;

  sait_audio_src u_src (.clk_in, .half_in(half), .left_in(wl), .right_in(wr),
    .bclk_out(bclk), .ws_out(ws), .data_out(dat));
  sait_audio_in u_dut (.clk_in, .srst_in, .audio_bclk_in(bclk), .audio_word_select_in(ws),
    .audio_data_lane_a_in(dat[0]), .audio_data_lane_b_in(dat[1]), .audio_data_lane_c_in(dat[2]),
    .audio_data_lane_d_in(dat[3]), .aux_data_in(dat[4]), .aux_en_in, .bclk_min_cycles_in,
    .embedded_mode_in, .emb_valid_in, .emb_word_in, .emb_slot_in, .island_disable_in,
    .legacy_partner_in, .surround_en_in, .upstream_surround_in, .tdm_mode_in, .tdm_eight_in,
    .video_blank_in, .cipher_active_in, .auth_busy_in, .link_lock_in, .tx_valid_out, .tx_word_out,
    .tx_slot_out, .tx_lane_out, .tx_island_out, .tx_encrypt_out, .overrun_out, .bclk_ok_out,
    .surround_active_out, .video_24bit_out, .ctrl_fwd_out, .ctrl_back_out);

  // ==========================================================
  // Clock, watchdog, word monitor
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    error_cnt++;
    end_of_test();
  end
  // Every sent word queued, so a missing or extra one shows
  always @(negedge clk_in) begin
    if (tx_valid_out === 1'b1) q.push_back({tx_lane_out, tx_slot_out, tx_word_out, tx_island_out, tx_encrypt_out});
    if (overrun_out === 1'b1) n_ovr++;
  end

  // ==========================================================
  // Helpers
  task automatic rnd(output logic [31:0] v);
    lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
    v = lfsr_st;
  endtask : rnd
  function automatic logic [39:0] ent(input logic [2:0] l, input logic c, input logic [31:0] w,
                                      input logic i, input logic e);
    return {l, l[1:0], c, w, i, e};
  endfunction : ent
  // Empty queue yields unknown, never a match
  function automatic logic [39:0] pop();
    if (q.size() == 0) return 'x;
    return q.pop_front();
  endfunction : pop
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // One frame; late holds blanking low until the frame is over
  task automatic i2s_case(input logic [4:0] mask, input logic isl, input logic enc, input logic late);
    for (int l = 0; l < 5; l++) begin
      rnd(wl[l]);
      rnd(wr[l]);
    end
    q.delete();
    n_ovr = 0;
    u_src.play();
    repeat (20) @(negedge clk_in);
    if (late) begin
      chk(40'(q.size()), 40'h0);
      video_blank_in = 1'b1;
      repeat (20) @(negedge clk_in);
    end
    for (int c = int'(late); c < 2; c++) begin
      for (int l = 0; l < 5; l++) begin
        if (mask[l]) chk(pop(), ent(3'(l), c[0], c[0] ? wr[l] : wl[l], isl, enc));
      end
    end
    chk(40'(q.size()), 40'h0);
    chk(40'(n_ovr), 40'(late));
  endtask : i2s_case

  // ==========================================================
  // Main sequence
  initial begin
    error_cnt = 0;
    n_checks = 0;
    lfsr_st = 32'h2F9D4A7C;
    {srst_in, surround_en_in, video_blank_in, link_lock_in} = 4'hF;
    {aux_en_in, embedded_mode_in, emb_valid_in, island_disable_in, legacy_partner_in} = 5'h00;
    {upstream_surround_in, tdm_mode_in, tdm_eight_in, cipher_active_in, auth_busy_in} = 5'h00;
    {bclk_min_cycles_in, emb_word_in, emb_slot_in, half, wl, wr} = '0;
    half = 4'h4;
    repeat (12) @(negedge clk_in);
    chk(40'({tx_valid_out, overrun_out, bclk_ok_out, surround_active_out, video_24bit_out}), 40'h01);
    srst_in = 1'b0;
    for (int m = 0; m < 16; m++) begin
      {island_disable_in, legacy_partner_in, surround_en_in, upstream_surround_in} = 4'(m);
      repeat (3) @(negedge clk_in);
      chk(40'(surround_active_out), 40'(!m[3] && !m[2] && (m[1] || m[0])));
      if (!m[3] && !m[0]) chk(40'(video_24bit_out), 40'(!(m[2] && m[1])));
    end
    for (int i = 0; i < 24; i++) begin
      rnd(r);
      {auth_busy_in, link_lock_in} = r[1:0];
      @(negedge clk_in);
      chk(40'({ctrl_fwd_out, ctrl_back_out}), 40'({2{r[1] & r[0]}}));
    end
    // Frame transport stays clear under the cipher
    rnd(r);
    bclk_min_cycles_in = 7'(r[2:0]);
    {island_disable_in, legacy_partner_in, cipher_active_in} = 3'b101;
    i2s_case(5'b00001, 1'b0, 1'b0, 1'b0);
    chk(40'(bclk_ok_out), 40'h1);
    repeat (60) @(negedge clk_in);
    chk(40'(bclk_ok_out), 40'h0);
    legacy_partner_in = 1'b1;
    i2s_case(5'b00011, 1'b0, 1'b0, 1'b0);
    // Surround islands with aux, encrypted; then plain islands, blanking late
    {island_disable_in, legacy_partner_in, aux_en_in} = 3'b001;
    i2s_case(5'b11111, 1'b1, 1'b1, 1'b0);
    {surround_en_in, upstream_surround_in, aux_en_in, cipher_active_in, video_blank_in} = 5'h00;
    i2s_case(5'b00011, 1'b1, 1'b0, 1'b1);
    // Too fast against both limits: nothing accepted
    for (int f = 0; f < 2; f++) begin
      half = f[0] ? 4'h1 : 4'h4;
      bclk_min_cycles_in = f[0] ? 7'h00 : 7'h0A;
      i2s_case(5'b00000, 1'b1, 1'b0, 1'b0);
      chk(40'(bclk_ok_out), 40'h0);
    end
    // TDM on lane A in frame transport; select rise restarts slots
    {half, bclk_min_cycles_in, tdm_mode_in, tdm_eight_in, island_disable_in} = {4'h4, 7'h00, 3'b111};
    rnd(r);
    wl[0] = r;
    rnd(r);
    wr[0] = r;
    q.delete();
    u_src.play();
    repeat (20) @(negedge clk_in);
    e = pop();
    chk(40'(e[33:2]), 40'(wl[0]));
    chk(pop(), {3'h0, 3'h0, wr[0], 2'b00});
    chk(40'(q.size()), 40'h0);
    tdm_mode_in = 1'b0;
    // Embedded words in frame transport
    {embedded_mode_in, island_disable_in} = 2'b11;
    rnd(r);
    {emb_word_in, emb_slot_in, emb_valid_in} = {r, r[2:0], 1'b1};
    q.delete();
    @(negedge clk_in);
    emb_valid_in = 1'b0;
    repeat (10) @(negedge clk_in);
    chk(pop(), {3'h0, r[2:0], r, 2'b00});
    end_of_test();
  end
endmodule : test_serializer_audio_input_transport
`default_nettype wire
